// file: common/cibr_pkg.sv
// Constants shared by the identifier buffer register block
package cibr_pkg;

  // Register map, page numbers in paddr[7:4] and control byte address on APB
  localparam logic [3:0] TX_PAGE   = 4'h0;
  localparam logic [3:0] RX_PAGE   = 4'h1;
  localparam logic [7:0] CTRL_ADDR = 8'h20;

  // Field positions inside the second identifier byte
  localparam int unsigned SRR_BIT     = 4;
  localparam int unsigned IDE_BIT     = 3;
  localparam int unsigned RTR_STD_BIT = 4;
  // Field position inside the fourth identifier byte, extended mapping
  localparam int unsigned RTR_EXT_BIT = 0;

  // Arbitration field lengths in bits
  localparam logic [5:0] EXT_LEN = 6'h20;
  localparam logic [5:0] STD_LEN = 6'h0d;

  // Control and status bits
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_LOST  = 1;
  localparam int unsigned STAT_WIN   = 2;

  // Bit timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned BIT_TIME_NS   = 1000;
  localparam int unsigned BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  BIT_LAST      = 5'(BIT_CYCLES - 1);

  // Reset value of the buffer bytes
  localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// file: hw/cibr_id_unpack.sv
// Identifier bytes to fields and arbitration bit sequence
`timescale 1ns/100ps
module cibr_id_unpack (
  input  wire logic [7:0]  byte0,
  input  wire logic [7:0]  byte1,
  input  wire logic [7:0]  byte2,
  input  wire logic [7:0]  byte3,
  output logic      [28:0] ident,
  output logic             ide,
  output logic             srr,
  output logic             rtr,
  output logic      [31:0] arb_vec,
  output logic      [5:0]  arb_len
);

  wire [28:0] id_ext;
  wire [10:0] id_std;

  assign ide    = byte1[cibr_pkg::IDE_BIT];
  assign srr    = byte1[cibr_pkg::SRR_BIT];
  assign id_ext = {byte0, byte1[7:5], byte1[2:0], byte2, byte3[7:1]};
  assign id_std = {byte0, byte1[7:5]};
  assign ident  = ide ? id_ext : {18'h0, id_std};
  assign rtr    = ide ? byte3[cibr_pkg::RTR_EXT_BIT]
                      : byte1[cibr_pkg::RTR_STD_BIT];

  // Left aligned in bus order, so a plain compare ranks priority
  assign arb_vec = ide ? {id_ext[28:18], srr, ide, id_ext[17:0], rtr}
                       : {id_std, rtr, ide, 19'h0};
  assign arb_len = ide ? cibr_pkg::EXT_LEN : cibr_pkg::STD_LEN;

endmodule

// file: hw/cibr_id_pack.sv
// Received identifier fields to buffer bytes
`timescale 1ns/100ps
module cibr_id_pack (
  input  wire logic [28:0] ident,
  input  wire logic        ide,
  input  wire logic        srr,
  input  wire logic        rtr,
  output logic      [7:0]  byte0,
  output logic      [7:0]  byte1,
  output logic      [7:0]  byte2,
  output logic      [7:0]  byte3
);

  assign byte0 = ide ? ident[28:21] : ident[10:3];
  assign byte1 = ide ? {ident[20:18], srr, ide, ident[17:15]}
                     : {ident[2:0], rtr, ide, 3'h0};
  // Unused bytes in standard mapping read as zero
  assign byte2 = ide ? ident[14:7] : 8'h00;
  assign byte3 = ide ? {ident[6:0], rtr} : 8'h00;

endmodule

// file: hw/cibr_ident_regs.sv
// Identifier buffer registers with APB slave and arbitration sender
`timescale 1ns/100ps
module cibr_ident_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_store,
  input  wire logic [28:0] rx_ident,
  input  wire logic        rx_srr,
  input  wire logic        rx_ide,
  input  wire logic        rx_rtr,
  input  wire logic        can_rx,
  output logic             can_tx
);

  typedef enum logic {CIBR_IDLE, CIBR_SEND} cibr_arb_t;

  logic      [7:0]  tx_q [4];
  logic      [7:0]  rx_q [4];
  logic      [31:0] prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic             rx_meta_q;
  logic             rx_sync_q;
  cibr_arb_t        state_q;
  logic      [31:0] shift_q;
  logic      [5:0]  len_q;
  logic      [5:0]  bit_idx_q;
  logic      [4:0]  cnt_q;
  logic             can_tx_q;
  logic             lost_q;
  logic             win_q;

  wire [28:0] tx_ident;
  wire        tx_ide;
  wire [31:0] tx_arb;
  wire [5:0]  tx_len;
  wire [28:0] rx_ident_q;
  wire        rx_ide_q;
  wire        rx_srr_q;
  wire        rx_rtr_q;
  wire [31:0] rx_arb;
  wire [7:0]  pk_byte [4];

  // Address decode
  wire        setup   = psel & ~penable;
  wire        access  = psel & penable & pready_q;
  wire        aligned = paddr[1:0] == 2'h0;
  wire [1:0]  idx     = paddr[3:2];
  wire        hit_tx  = aligned & (paddr[7:4] == cibr_pkg::TX_PAGE);
  wire        hit_rx  = aligned & (paddr[7:4] == cibr_pkg::RX_PAGE);
  wire        hit_ctl = paddr == cibr_pkg::CTRL_ADDR;
  wire        mapped  = hit_tx | hit_rx | hit_ctl;
  wire        busy    = state_q == CIBR_SEND;
  // Buffer is frozen while its identifier is on the bus
  wire        wr_tx   = access & pwrite & hit_tx & ~busy;
  wire        start   = access & pwrite & hit_ctl & ~busy
                        & pwdata[cibr_pkg::CTRL_START];
  wire [7:0]  status  = {5'h0, win_q, lost_q, busy};
  wire [31:0] rd_mux  = hit_tx  ? {24'h0, tx_q[idx]} :
                        hit_rx  ? {24'h0, rx_q[idx]} :
                        hit_ctl ? {24'h0, status} : 32'h0;
  wire        tick    = busy & (cnt_q == cibr_pkg::BIT_LAST);
  // Recessive sent but dominant seen means another node wins
  wire        lose    = tick & can_tx_q & ~rx_sync_q;
  wire        last    = bit_idx_q == len_q - 6'h01;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign can_tx  = can_tx_q;

  cibr_id_unpack u_tx_unpack (
    .byte0   (tx_q[0]),
    .byte1   (tx_q[1]),
    .byte2   (tx_q[2]),
    .byte3   (tx_q[3]),
    .ident   (tx_ident),
    .ide     (tx_ide),
    .srr     (),
    .rtr     (),
    .arb_vec (tx_arb),
    .arb_len (tx_len)
  );

  cibr_id_unpack u_rx_unpack (
    .byte0   (rx_q[0]),
    .byte1   (rx_q[1]),
    .byte2   (rx_q[2]),
    .byte3   (rx_q[3]),
    .ident   (rx_ident_q),
    .ide     (rx_ide_q),
    .srr     (rx_srr_q),
    .rtr     (rx_rtr_q),
    .arb_vec (rx_arb),
    .arb_len ()
  );

  cibr_id_pack u_rx_pack (
    .ident (rx_ident),
    .ide   (rx_ide),
    .srr   (rx_srr),
    .rtr   (rx_rtr),
    .byte0 (pk_byte[0]),
    .byte1 (pk_byte[1]),
    .byte2 (pk_byte[2]),
    .byte3 (pk_byte[3])
  );

  // APB answer one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= setup ? rd_mux : 32'h0;
    end
  end

  // Per byte buffer storage
  for (genvar i = 0; i < 4; i++) begin : g_byte
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_q[i] <= cibr_pkg::BYTE_RST;
        rx_q[i] <= cibr_pkg::BYTE_RST;
      end else begin
        // Transmit bytes kept as written, SRR included
        if (wr_tx && idx == 2'(i)) begin
          tx_q[i] <= pwdata[7:0];
        end
        if (rx_store) begin
          rx_q[i] <= pk_byte[i];
        end
      end
    end
  end

  // Bus pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= can_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Smaller arbitration field wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q <= 1'b0;
    end else begin
      win_q <= tx_arb < rx_arb;
    end
  end

  // Bit rate enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h0;
    end else if (!busy || tick) begin
      cnt_q <= 5'h0;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Arbitration sender, most significant bit first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= CIBR_IDLE;
      shift_q   <= 32'h0;
      len_q     <= 6'h0;
      bit_idx_q <= 6'h0;
      can_tx_q  <= 1'b1;
      lost_q    <= 1'b0;
    end else begin
      case (state_q)
        CIBR_IDLE: begin
          if (start) begin
            state_q   <= CIBR_SEND;
            shift_q   <= tx_arb;
            len_q     <= tx_len;
            bit_idx_q <= 6'h0;
            can_tx_q  <= tx_arb[31];
            lost_q    <= 1'b0;
          end
        end
        CIBR_SEND: begin
          if (lose) begin
            state_q  <= CIBR_IDLE;
            can_tx_q <= 1'b1;
            lost_q   <= 1'b1;
          end else if (tick && last) begin
            state_q  <= CIBR_IDLE;
            can_tx_q <= 1'b1;
          end else if (tick) begin
            shift_q   <= {shift_q[30:0], 1'b0};
            can_tx_q  <= shift_q[30];
            bit_idx_q <= bit_idx_q + 6'h01;
          end
        end
        default: begin
          state_q  <= CIBR_IDLE;
          can_tx_q <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_store_ext;
    rx_store && rx_ide;
  endsequence

  sequence s_store_std;
    rx_store && !rx_ide;
  endsequence

  property p_len_ext;
    start && tx_ide |=> len_q == cibr_pkg::EXT_LEN;
  endproperty
  a_len_ext: assert property (p_len_ext)
    else $error("extended length not 32");

  property p_len_std;
    start && !tx_ide |=> len_q == cibr_pkg::STD_LEN;
  endproperty
  a_len_std: assert property (p_len_std)
    else $error("standard length not 13");

  property p_ext_byte0;
    s_store_ext |=> rx_q[0] == $past(rx_ident[28:21]) &&
                    rx_ident_q[17:15] == $past(rx_ident[17:15]);
  endproperty
  a_ext_byte0: assert property (p_ext_byte0)
    else $error("extended id high bits misplaced");

  property p_ext_low;
    s_store_ext |=> rx_q[2] == $past(rx_ident[14:7]) &&
                    rx_q[3][7:1] == $past(rx_ident[6:0]);
  endproperty
  a_ext_low: assert property (p_ext_low)
    else $error("extended id low bits misplaced");

  property p_first_bit;
    start |=> busy && can_tx_q == $past(tx_arb[31]) &&
              shift_q[31] == $past(tx_ide ? tx_ident[28] : tx_ident[10]);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first arbitration bit not id msb");

  // Leading byte alone settles priority when it differs
  property p_win;
    tx_q[0] < rx_q[0] |=> win_q;
  endproperty
  a_win: assert property (p_win)
    else $error("priority compare wrong");

  property p_lost;
    lose |=> !busy && lost_q && can_tx_q ##1 !busy;
  endproperty
  a_lost: assert property (p_lost)
    else $error("arbitration loss not handled");

  property p_srr;
    s_store_ext |=> rx_srr_q == $past(rx_srr);
  endproperty
  a_srr: assert property (p_srr)
    else $error("received srr not kept");

  property p_ide;
    rx_store |=> rx_ide_q == $past(rx_ide);
  endproperty
  a_ide: assert property (p_ide)
    else $error("received ide not kept");

  property p_rtr;
    s_store_ext |=> rx_q[3][cibr_pkg::RTR_EXT_BIT] == $past(rx_rtr) &&
                    rx_rtr_q == $past(rx_rtr);
  endproperty
  a_rtr: assert property (p_rtr)
    else $error("received rtr not kept");

  property p_std;
    s_store_std |=> rx_q[0] == $past(rx_ident[10:3]) &&
                    rx_q[1][7:5] == $past(rx_ident[2:0]);
  endproperty
  a_std: assert property (p_std)
    else $error("standard id misplaced");

  property p_std_zero;
    s_store_std |=> rx_q[1][2:0] == '0 && rx_q[2] == '0 && rx_q[3] == '0;
  endproperty
  a_std_zero: assert property (p_std_zero)
    else $error("standard unused bits not zero");

  property p_msb_first;
    start |=> can_tx_q == $past(tx_q[0][7]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit not top of first byte");

  // A bit may only change at the end of its time
  property p_hold;
    busy && !tick |=> $stable(can_tx_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus bit changed mid bit");

  property p_done;
    tick && last && !lose |=> !busy && can_tx_q;
  endproperty
  a_done: assert property (p_done)
    else $error("sender not idle after last bit");

  property p_lost_kept;
    lost_q && !start |=> lost_q;
  endproperty
  a_lost_kept: assert property (p_lost_kept)
    else $error("lost flag dropped without start");

  // Software can never alter what was received
  property p_ro_rx;
    !rx_store |=> $stable(rx_q[0]) && $stable(rx_q[1]) &&
                  $stable(rx_q[2]) && $stable(rx_q[3]);
  endproperty
  a_ro_rx: assert property (p_ro_rx)
    else $error("receive bytes changed without store");

endmodule

// file: tb/cibr_can_node.sv
// Other bus node: wired-AND contender for arbitration
`timescale 1ns/100ps
module cibr_can_node (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [31:0] vec,
  input  wire logic        can_tx,
  output logic             can_rx
);
  logic [31:0] sh_q;
  logic [4:0]  cyc_q;
  logic [5:0]  left_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q   <= '1;
      cyc_q  <= 5'h00;
      left_q <= 6'h00;
    end else if (go) begin
      sh_q   <= vec;
      cyc_q  <= 5'h00;
      left_q <= 6'h20;
    end else if (left_q != 6'h00) begin
      cyc_q <= (cyc_q == 5'h18) ? 5'h00 : cyc_q + 5'h01;
      if (cyc_q == 5'h18) begin
        sh_q   <= {sh_q[30:0], 1'b1};
        left_q <= left_q - 6'h01;
      end
    end
  end
  // Dominant zero wins; released node is recessive
  assign can_rx = can_tx & ((left_q == 6'h00) | sh_q[31]);
endmodule

// file: tb/cibr_ident_regs_tb.sv
// Testbench for the identifier buffer registers
`timescale 1ns/100ps
module cibr_ident_regs_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        rx_store = 0, rx_srr = 0, rx_ide = 0, rx_rtr = 0, go = 0;
  logic        can_rx, can_tx, pready, pslverr, e;
  logic [7:0]  paddr = 8'h00;
  logic [28:0] rx_ident = 29'h0, id;
  logic [31:0] pwdata = 32'h0, vec = 32'h0, prdata, r, ex, sq;
  int          n_errors = 0, n_tests = 0;

  always #20 pclk = ~pclk;

  cibr_ident_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_store(rx_store), .rx_ident(rx_ident), .rx_srr(rx_srr),
    .rx_ide(rx_ide), .rx_rtr(rx_rtr), .can_rx(can_rx), .can_tx(can_tx));
  cibr_can_node node (.pclk(pclk), .presetn(presetn), .go(go), .vec(vec),
    .can_tx(can_tx), .can_rx(can_rx));

  function automatic logic [31:0] ext_b(logic [28:0] i, logic s, logic t);
    return {i[28:18], s, 1'b1, i[17:0], t};
  endfunction
  function automatic logic [31:0] std_b(logic [10:0] i, logic t);
    return {i[10:0], t, 1'b0, 19'h0};
  endfunction

  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Idle cycle after each transfer avoids double drive in one step
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr4(logic [7:0] b, logic [31:0] v);
    for (int i = 0; i < 4; i++)
      apb(1'b1, b + 8'(4 * i), {24'hffffff, v[31 - 8 * i -: 8]}, r, e);
  endtask
  task automatic rd4(logic [7:0] b, logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, b + 8'(4 * i), 32'h0, r, e);
      chk("ident byte", r, {24'h0, v[31 - 8 * i -: 8]});
    end
  endtask
  task automatic store(logic [28:0] i, logic s, logic d, logic t);
    rx_ident <= i;
    rx_srr <= s;
    rx_ide <= d;
    rx_rtr <= t;
    rx_store <= 1'b1;
    @(posedge pclk);
    rx_store <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd4(8'h00, 32'h0);
    rd4(8'h10, 32'h0);
    chk("idle tx", {31'h0, can_tx}, 32'h1);
    // Extended transmit buffer, upper pwdata bits must not stick
    id = 29'h15a3c96b;
    ex = ext_b(id, 1'b1, 1'b1);
    sq = {id[28:18], 1'b1, 1'b1, id[17:0], 1'b1};
    wr4(8'h00, ex);
    rd4(8'h00, ex);
    apb(1'b1, 8'h10, 32'h5a, r, e);
    rd4(8'h10, 32'h0);
    apb(1'b0, 8'h24, 32'h0, r, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(1'b1, cibr_pkg::CTRL_ADDR, 32'h1, r, e);
    apb(1'b1, 8'h00, 32'h0, r, e);
    repeat (8) @(posedge pclk);
    for (int i = 31; i >= 0; i--) begin
      chk("ext bit", {31'h0, can_tx}, {31'h0, sq[i]});
      repeat (25) @(posedge pclk);
    end
    apb(1'b0, cibr_pkg::CTRL_ADDR, 32'h0, r, e);
    chk("status done", r & 32'h3, 32'h0);
    rd4(8'h00, ex);
    // Receive side keeps the bits as seen, except SRR in standard mapping
    store(29'h0abcdef1, 1'b0, 1'b1, 1'b0);
    rd4(8'h10, ext_b(29'h0abcdef1, 1'b0, 1'b0));
    store(29'h000005a3, 1'b1, 1'b0, 1'b1);
    rd4(8'h10, std_b(11'h5a3, 1'b1));
    // Transmit id 0x15a3c96b leads with 0x568, below received 0x5a3
    apb(1'b0, cibr_pkg::CTRL_ADDR, 32'h0, r, e);
    chk("status win", r, 32'h4);
    // Lower identifier from the other node wins at the first bit
    wr4(8'h00, std_b(11'h400, 1'b0));
    vec <= {11'h3ff, 2'b00, 19'h7ffff};
    apb(1'b1, cibr_pkg::CTRL_ADDR, 32'h1, r, e);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("lost tx", {31'h0, can_tx}, 32'h1);
    apb(1'b0, cibr_pkg::CTRL_ADDR, 32'h0, r, e);
    chk("status lost", r & 32'h3, 32'h2);
    finish_test;
  end
endmodule
